/* File: core/pic_command_port.sv */
// serial command port of the power manager: bus slave, holding latches, command registers
//
// Contract
// - ack write address, pointer and data bytes
// - ack read address, return bytes until master nack
// - hold data low through ack clock high
// - answer 0x68 write, 0x69 read
// - fourteen writable command registers by pointer
// - write is address, pointer, data pairs
// - data latched when its ack starts
// - repeated start elsewhere keeps pending data
// - commit latches to registers only on stop
// - pointer written first, then repeated-start read
// - read shifts eight bits, msb first
// - no stop needed, pointer kept
// - reads before stop return pending data
// - each new read repeats same register
// - mode register holds three buck modes
// - mode bit 6 selects buck-boost burst
// - enable bits ored with pins when bit7 low
// - bit7 high uses register bits only
// - power-on pin low clears enable register
// - mask bit gates power-good timeout shutdown
// - start-up bits select discharge wait
// - masked timeout keeps power-good normal
// - supply collapse resets port and registers
`timescale 1ns/1ps
module pic_command_port import pic_pkg::*; #(
  parameter int PG_TIMEOUT_CYC = PIC_PG_TIMEOUT_CYC,
  parameter int FILT_CYC       = PIC_FILT_CYC
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       interface_supply_ok_i,
  // serial bus, open drain data
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // enable pins
  input  wire logic       power_on_input_i,
  input  wire logic       buck1_enable_pin_i,
  input  wire logic       buck2_enable_pin_i,
  input  wire logic       buck3_enable_pin_i,
  input  wire logic       buckboost_enable_pin_i,
  input  wire logic       linreg2_enable_pin_i,
  input  wire logic       linreg34_enable_pin_i,
  // power-good monitor
  input  wire logic       power_good_output_low_i,
  output logic            power_good_output_o,
  output logic            power_good_output_timeout_o,
  output logic            hard_shutdown_o,
  // regulator controls
  output logic [6:0]      regulator_enable_o,
  output pic_mode_t       buck1_mode_o,
  output pic_mode_t       buck2_mode_o,
  output pic_mode_t       buck3_mode_o,
  output logic            buckboost_burst_o,
  output logic [6:0]      startup_wait_o
);
  logic            port_rst;
  logic            sda_lvl;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_det;
  logic            stop_det;
  pic_state_t      st_reg;
  logic [7:0]      sh_reg;
  logic [3:0]      bit_cnt_reg;
  logic            rd_mode_reg;
  logic            expect_ptr_reg;
  logic            sda_oe_reg;
  logic [7:0]      ptr_reg;
  logic [7:0]      hold_reg [PIC_REG_NUM];
  logic [7:0]      act_reg  [PIC_REG_NUM];
  logic [PIC_REG_NUM-1:0] pend_reg;
  logic [3:0]      ptr_idx;
  logic [7:0]      rd_byte;
  logic            byte_done;
  logic            ptr_stb;
  logic            data_stb;
  logic            oe_clear;
  logic [6:0]      pin_en;
  logic [6:0]      en_reg;
  logic [31:0]     pg_cnt_reg;
  logic            pg_fire;
  logic            power_good_output_reg;

  // supply collapse returns the whole port to its power-on state
  assign port_rst = !rstn_i || !interface_supply_ok_i;

  pic_bus_sampler #(
    .FILT_CYC (FILT_CYC)
  ) u_smp (
    .clk_i      (clk_i),
    .rstn_i     (!port_rst),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_lvl_o  (sda_lvl),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_det),
    .stop_o     (stop_det)
  );

  assign ptr_idx   = pic_reg_index(ptr_reg);
  assign byte_done = scl_fall && bit_cnt_reg == 4'h8;
  assign ptr_stb   = st_reg == PIC_ST_WR && byte_done && expect_ptr_reg;
  assign data_stb  = st_reg == PIC_ST_WR && byte_done && !expect_ptr_reg;

  // uncommitted data wins so the master can verify before its stop
  always_comb begin
    rd_byte = PIC_UNMAPPED_RD;
    if (ptr_idx != PIC_NO_IDX) begin
      rd_byte = pend_reg[ptr_idx] ? hold_reg[ptr_idx] : act_reg[ptr_idx];
    end
  end

  // bus protocol engine; sda changes only after scl falls so it is stable while high
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      st_reg         <= PIC_ST_IDLE;
      sh_reg         <= 8'h00;
      bit_cnt_reg    <= 4'h0;
      rd_mode_reg    <= 1'b0;
      expect_ptr_reg <= 1'b0;
      sda_oe_reg     <= 1'b0;
    end else if (stop_det) begin
      st_reg     <= PIC_ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      // a repeated start to another address leaves the latches alone
      st_reg      <= PIC_ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg  <= 1'b0;
    end else begin
      case (st_reg)
        PIC_ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        PIC_ST_ADDR, PIC_ST_WR: begin
          if (scl_rise && bit_cnt_reg != 4'h8) begin
            sh_reg      <= {sh_reg[6:0], sda_lvl};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            bit_cnt_reg <= 4'h0;
            if (st_reg == PIC_ST_WR) begin
              st_reg         <= PIC_ST_ACK;
              sda_oe_reg     <= 1'b1;
              expect_ptr_reg <= !expect_ptr_reg;
            end else if (sh_reg == PIC_WR_ADDR || sh_reg == PIC_RD_ADDR) begin
              st_reg         <= PIC_ST_ACK;
              sda_oe_reg     <= 1'b1;
              rd_mode_reg    <= sh_reg[0];
              expect_ptr_reg <= 1'b1;
            end else begin
              st_reg <= PIC_ST_IDLE;
            end
          end
        end
        PIC_ST_ACK: begin
          if (scl_fall) begin
            if (rd_mode_reg) begin
              // first data bit goes out on the fall that ends the ack
              st_reg      <= PIC_ST_RD;
              sh_reg      <= {rd_byte[6:0], 1'b0};
              sda_oe_reg  <= !rd_byte[7];
              bit_cnt_reg <= 4'h1;
            end else begin
              st_reg      <= PIC_ST_WR;
              sda_oe_reg  <= 1'b0;
              bit_cnt_reg <= 4'h0;
            end
          end
        end
        PIC_ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h8) begin
              st_reg     <= PIC_ST_RD_ACK;
              sda_oe_reg <= 1'b0;
            end else begin
              sh_reg      <= {sh_reg[6:0], 1'b0};
              sda_oe_reg  <= !sh_reg[7];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        PIC_ST_RD_ACK: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_lvl};
          end else if (scl_fall) begin
            if (sh_reg[0]) begin
              st_reg <= PIC_ST_IDLE;
            end else begin
              // master asked for more: repeat the same register
              st_reg      <= PIC_ST_RD;
              sh_reg      <= {rd_byte[6:0], 1'b0};
              sda_oe_reg  <= !rd_byte[7];
              bit_cnt_reg <= 4'h1;
            end
          end
        end
        default: begin
          st_reg     <= PIC_ST_IDLE;
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_reg;

  // read pointer survives reads, starts and stops
  always_ff @(posedge clk_i) begin
    if (port_rst)     ptr_reg <= 8'h00;
    else if (ptr_stb) ptr_reg <= sh_reg;
  end

  // a hard shutdown wipes the enables just as the power-on pin does
  assign oe_clear = !power_on_input_i || hard_shutdown_o;

  // holding latches, filled as each data ack starts
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      pend_reg <= '0;
      for (int i = 0; i < PIC_REG_NUM; i++) hold_reg[i] <= PIC_REG_RST;
    end else begin
      if (stop_det) pend_reg <= '0;
      if (data_stb && ptr_idx != PIC_NO_IDX) begin
        hold_reg[ptr_idx] <= sh_reg;
        pend_reg[ptr_idx] <= 1'b1;
      end
      // an enable clear must not be undone by a later stop
      if (oe_clear) pend_reg[PIC_OE_IDX] <= 1'b0;
    end
  end

  // active command registers
  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      for (int i = 0; i < PIC_REG_NUM; i++) act_reg[i] <= PIC_REG_RST;
    end else begin
      if (stop_det) begin
        for (int i = 0; i < PIC_REG_NUM; i++) begin
          if (pend_reg[i]) act_reg[i] <= hold_reg[i];
        end
      end
      if (oe_clear) act_reg[PIC_OE_IDX] <= PIC_REG_RST;
    end
  end

  // pin order matches enable register bits 0..6; the shared linear pin drives bits 5 and 6
  assign pin_en = {linreg34_enable_pin_i, linreg34_enable_pin_i, linreg2_enable_pin_i,
                   buckboost_enable_pin_i, buck3_enable_pin_i, buck2_enable_pin_i,
                   buck1_enable_pin_i};

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      en_reg <= 7'h00;
    end else if (act_reg[PIC_OE_IDX][PIC_OE_SW_BIT]) begin
      en_reg <= act_reg[PIC_OE_IDX][6:0];
    end else begin
      en_reg <= act_reg[PIC_OE_IDX][6:0] | pin_en;
    end
  end

  assign regulator_enable_o = en_reg;
  assign buck1_mode_o       = pic_mode_t'(act_reg[PIC_MODE_IDX][PIC_B1_LSB +: 2]);
  assign buck2_mode_o       = pic_mode_t'(act_reg[PIC_MODE_IDX][PIC_B2_LSB +: 2]);
  assign buck3_mode_o       = pic_mode_t'(act_reg[PIC_MODE_IDX][PIC_B3_LSB +: 2]);
  assign buckboost_burst_o  = act_reg[PIC_MODE_IDX][PIC_BB_BIT];
  // a zero start-up bit means wait for the output to discharge
  assign startup_wait_o     = ~act_reg[PIC_STARTUP_IDX][6:0];

  // power-good timeout: reporting is unconditional, shutdown only when unmasked
  assign pg_fire = power_good_output_low_i && pg_cnt_reg == 32'(PG_TIMEOUT_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (port_rst) begin
      pg_cnt_reg      <= 32'h0;
      power_good_output_timeout_o <= 1'b0;
      hard_shutdown_o <= 1'b0;
      power_good_output_reg       <= 1'b0;
    end else begin
      power_good_output_reg       <= !power_good_output_low_i;
      power_good_output_timeout_o <= pg_fire;
      hard_shutdown_o <= pg_fire && !act_reg[PIC_STARTUP_IDX][PIC_MASK_BIT];
      if (!power_good_output_low_i) pg_cnt_reg <= 32'h0;
      else if (pg_cnt_reg != 32'(PG_TIMEOUT_CYC)) pg_cnt_reg <= pg_cnt_reg + 32'h1;
    end
  end

  assign power_good_output_o = power_good_output_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (port_rst);

  property p_addr_ack;
    st_reg == PIC_ST_ADDR && byte_done && !start_det && !stop_det && sh_reg[7:1] == PIC_WR_ADDR[7:1]
      |=> sda_oe_o && st_reg == PIC_ST_ACK && rd_mode_reg == $past(sh_reg[0]);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("own address not acked");
  property p_foreign_addr;
    st_reg == PIC_ST_ADDR && byte_done && !start_det && !stop_det && sh_reg[7:1] != PIC_WR_ADDR[7:1]
      |=> !sda_oe_o && st_reg == PIC_ST_IDLE;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("foreign address acked");
  property p_byte_ack;
    st_reg == PIC_ST_WR && byte_done && !start_det && !stop_det
      |=> sda_oe_o throughout (st_reg == PIC_ST_ACK)[*1];
  endproperty
  a_byte_ack: assert property (p_byte_ack) else $error("write byte not acked");
  property p_ack_stable;
    st_reg == PIC_ST_ACK && !scl_fall && !start_det && !stop_det |=> sda_oe_o;
  endproperty
  a_ack_stable: assert property (p_ack_stable) else $error("ack released early");
  // an enable clear in the same cycle legitimately drops the pending enable write
  property p_latch;
    data_stb && !stop_det && !oe_clear && ptr_idx != PIC_NO_IDX
      |=> hold_reg[$past(ptr_idx)] == $past(sh_reg) && pend_reg[$past(ptr_idx)];
  endproperty
  a_latch: assert property (p_latch) else $error("data byte not latched");
  property p_commit_on_stop;
    !stop_det && power_on_input_i && !hard_shutdown_o |=> $stable(act_reg[PIC_OE_IDX]);
  endproperty
  a_commit_on_stop: assert property (p_commit_on_stop) else $error("commit without stop");
  property p_pend_clear;
    stop_det |=> pend_reg == '0;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending kept after stop");
  property p_read_msb;
    st_reg == PIC_ST_ACK && rd_mode_reg && scl_fall && !start_det && !stop_det
      |=> sda_oe_o == !$past(rd_byte[7]);
  endproperty
  a_read_msb: assert property (p_read_msb) else $error("read msb wrong");
  property p_ptr_kept;
    !ptr_stb |=> $stable(ptr_reg);
  endproperty
  a_ptr_kept: assert property (p_ptr_kept) else $error("pointer changed");
  property p_sw_only;
    act_reg[PIC_OE_IDX][PIC_OE_SW_BIT] ##1 $stable(act_reg[PIC_OE_IDX])
      |-> regulator_enable_o == act_reg[PIC_OE_IDX][6:0];
  endproperty
  a_sw_only: assert property (p_sw_only) else $error("pins not ignored");
  property p_power_off;
    !power_on_input_i |=> act_reg[PIC_OE_IDX] == PIC_REG_RST ##1 !regulator_enable_o[0]
      || buck1_enable_pin_i || $past(buck1_enable_pin_i);
  endproperty
  a_power_off: assert property (p_power_off) else $error("enable not cleared");
  // the shutdown pulse was decided from the mask bit one cycle earlier
  property p_mask;
    hard_shutdown_o |-> power_good_output_timeout_o && !$past(act_reg[PIC_STARTUP_IDX][PIC_MASK_BIT]);
  endproperty
  a_mask: assert property (p_mask) else $error("masked shutdown fired");
  c_write:  cover property (data_stb ##[1:1000] stop_det);
  c_read:   cover property (st_reg == PIC_ST_RD_ACK ##[1:100] st_reg == PIC_ST_IDLE);
  c_reread: cover property (st_reg == PIC_ST_RD_ACK ##[1:100] st_reg == PIC_ST_RD);
  c_shdn:   cover property (hard_shutdown_o);
endmodule : pic_command_port

/* File: core/pic_pkg.sv */
// package: constants, types and register decode for the serial command port
package pic_pkg;
  // bus addresses
  localparam logic [7:0] PIC_WR_ADDR     = 8'h68;
  localparam logic [7:0] PIC_RD_ADDR     = 8'h69;
  // register map
  localparam int         PIC_REG_NUM     = 14;
  localparam int         PIC_SPARE_NUM   = PIC_REG_NUM - 3;
  localparam logic [7:0] PIC_MODE_OFS    = 8'h07;
  localparam logic [7:0] PIC_OE_OFS      = 8'h10;
  localparam logic [7:0] PIC_STARTUP_OFS = 8'h12;
  localparam logic [7:0] PIC_SPARE_OFS   = 8'h20;
  localparam logic [3:0] PIC_MODE_IDX    = 4'h0;
  localparam logic [3:0] PIC_OE_IDX      = 4'h1;
  localparam logic [3:0] PIC_STARTUP_IDX = 4'h2;
  localparam logic [3:0] PIC_SPARE_IDX0  = 4'h3;
  localparam logic [3:0] PIC_NO_IDX      = 4'hF;
  localparam logic [7:0] PIC_REG_RST     = 8'h00;
  localparam logic [7:0] PIC_UNMAPPED_RD = 8'h00;
  // field positions
  localparam int         PIC_B1_LSB      = 0;
  localparam int         PIC_B2_LSB      = 2;
  localparam int         PIC_B3_LSB      = 4;
  localparam int         PIC_BB_BIT      = 6;
  localparam int         PIC_OE_SW_BIT   = 7;
  localparam int         PIC_MASK_BIT    = 7;
  // timing
  localparam int         PIC_CLK_MHZ     = 200;
  localparam int         PIC_PG_TIMEOUT_MS  = 14;
  localparam int         PIC_PG_TIMEOUT_CYC = PIC_PG_TIMEOUT_MS * 1000 * PIC_CLK_MHZ;
  localparam int         PIC_GLITCH_NS   = 50;
  localparam int         PIC_FILT_CYC    = PIC_GLITCH_NS * PIC_CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    PIC_PULSE_SKIP  = 2'h0,
    PIC_BURST       = 2'h1,
    PIC_FORCED_CONT = 2'h2
  } pic_mode_t;

  typedef enum logic [5:0] {
    PIC_ST_IDLE   = 6'h01,
    PIC_ST_ADDR   = 6'h02,
    PIC_ST_ACK    = 6'h04,
    PIC_ST_WR     = 6'h08,
    PIC_ST_RD     = 6'h10,
    PIC_ST_RD_ACK = 6'h20
  } pic_state_t;

  // map a register pointer to a storage index, PIC_NO_IDX when unmapped
  function automatic logic [3:0] pic_reg_index(input logic [7:0] ofs);
    logic [7:0] d;
    d = ofs - PIC_SPARE_OFS;
    if (ofs == PIC_MODE_OFS) return PIC_MODE_IDX;
    if (ofs == PIC_OE_OFS) return PIC_OE_IDX;
    if (ofs == PIC_STARTUP_OFS) return PIC_STARTUP_IDX;
    if (d < 8'(PIC_SPARE_NUM)) return d[3:0] + PIC_SPARE_IDX0;
    return PIC_NO_IDX;
  endfunction : pic_reg_index
endpackage : pic_pkg

/* File: core/pic_bus_sampler.sv */
// glitch filter and start, stop and clock edge detection for the two bus lines
`timescale 1ns/1ps
module pic_bus_sampler import pic_pkg::*; #(
  parameter int FILT_CYC = PIC_FILT_CYC
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // bus lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // conditions
  output logic      sda_lvl_o,
  output logic      scl_rise_o,
  output logic      scl_fall_o,
  output logic      start_o,
  output logic      stop_o
);
  logic [1:0] raw;
  logic [1:0] filt;
  logic [1:0] prev_reg;

  assign raw = {sda_i, scl_i};

  // a line changes only after it has held its new level for FILT_CYC cycles
  for (genvar g = 0; g < 2; g++) begin : g_filt
    logic [7:0] cnt_reg;
    logic       lvl_reg;
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        cnt_reg <= 8'h00;
        lvl_reg <= 1'b1;
      end else if (raw[g] == lvl_reg) begin
        cnt_reg <= 8'h00;
      end else if (cnt_reg >= 8'(FILT_CYC - 1)) begin
        cnt_reg <= 8'h00;
        lvl_reg <= raw[g];
      end else begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
    assign filt[g] = lvl_reg;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) prev_reg <= 2'h3;
    else         prev_reg <= filt;
  end

  assign sda_lvl_o  = filt[1];
  assign scl_rise_o = filt[0] & ~prev_reg[0];
  assign scl_fall_o = ~filt[0] & prev_reg[0];
  assign start_o    = filt[0] & prev_reg[0] & prev_reg[1] & ~filt[1];
  assign stop_o     = filt[0] & prev_reg[0] & ~prev_reg[1] & filt[1];
endmodule : pic_bus_sampler

/* File: dv/pic_bus_master.sv */
// two-wire bus master model that talks to the command port
`timescale 1ns/1ps
module pic_bus_master #(
  parameter int HP = 8
) (
  // clock and resolved data line
  input  wire logic clk_i,
  input  wire logic sda_i,
  // driven lines, 1 releases the line to its pull-up
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic hp(input int n);
    repeat (n) @(negedge clk_i);
  endtask : hp

  // data moves only mid low phase so filtered edges never mimic start or stop
  task automatic bit_io(input logic b, output logic got);
    hp(HP / 2);
    sda_o = b;
    hp(HP / 2);
    scl_o = 1'b1;
    hp(3);
    got = sda_i;
    hp(HP - 4);
    got = got | sda_i; // low only if low early and late in the high phase
    hp(1);
    scl_o = 1'b0;
  endtask : bit_io

  task automatic start_cond();
    hp(HP / 2);
    sda_o = 1'b1;
    hp(HP / 2);
    scl_o = 1'b1;
    hp(HP);
    sda_o = 1'b0;
    hp(HP);
    scl_o = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    hp(HP / 2);
    sda_o = 1'b0;
    hp(HP / 2);
    scl_o = 1'b1;
    hp(HP);
    sda_o = 1'b1;
    hp(HP);
  endtask : stop_cond

  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(b[i], g);
    bit_io(1'b1, g);
    ack = ~g;
  endtask : wr_byte

  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~mack, g);
  endtask : rd_byte
endmodule : pic_bus_master

/* File: dv/test_pic_command_port.sv */
// self-checking bench for the serial command port
`timescale 1ns/1ps
module test_pic_command_port import pic_pkg::*; ;
  localparam int PG_CYC  = 50;
  localparam int MAX_CYC = 30000;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] dat;
    logic [5:0] pins;
    logic [7:0] exp;
  } pic_row_t;
  localparam pic_row_t ROWS [7] = '{
    '{8'h07, 8'h24, 6'h00, 8'h24}, '{8'h07, 8'h46, 6'h00, 8'h46},
    '{8'h07, 8'h19, 6'h00, 8'h19}, '{8'h10, 8'h05, 6'h02, 8'h07},
    '{8'h10, 8'h00, 6'h20, 8'h60}, '{8'h10, 8'h81, 6'h3F, 8'h01},
    '{8'h12, 8'h0F, 6'h00, 8'h70}};

  logic       clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       supply_ok = 1'b1;
  logic       power_on_input = 1'b1;
  logic       power_good_output_low = 1'b0;
  logic [5:0] pins = 6'h00;
  logic       scl;
  logic       m_sda;
  logic       dut_sda;
  logic       dut_oe;
  wire        sda_w = m_sda & (dut_oe ? dut_sda : 1'b1);
  logic [6:0] regulator_enable_o;
  logic [6:0] startup_wait_o;
  pic_mode_t  buck1_mode_o;
  pic_mode_t  buck2_mode_o;
  pic_mode_t  buck3_mode_o;
  logic       buckboost_burst_o;
  logic       power_good_output_o;
  logic       power_good_output_timeout_o;
  logic       hard_shutdown_o;
  logic [7:0] d;
  logic       a;
  int         err_total = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         sd_cnt = 0;
  int         to_cnt = 0;

  always #2.5 clk_i = ~clk_i;

  pic_command_port #(.PG_TIMEOUT_CYC(PG_CYC), .FILT_CYC(2)) dut_u (
    .clk_i(clk_i), .rstn_i(rstn_i), .interface_supply_ok_i(supply_ok),
    .scl_i(scl), .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(dut_oe),
    .power_on_input_i(power_on_input), .buck1_enable_pin_i(pins[0]),
    .buck2_enable_pin_i(pins[1]), .buck3_enable_pin_i(pins[2]),
    .buckboost_enable_pin_i(pins[3]), .linreg2_enable_pin_i(pins[4]),
    .linreg34_enable_pin_i(pins[5]), .power_good_output_low_i(power_good_output_low),
    .power_good_output_o(power_good_output_o), .power_good_output_timeout_o(power_good_output_timeout_o),
    .hard_shutdown_o(hard_shutdown_o), .regulator_enable_o(regulator_enable_o),
    .buck1_mode_o(buck1_mode_o), .buck2_mode_o(buck2_mode_o),
    .buck3_mode_o(buck3_mode_o), .buckboost_burst_o(buckboost_burst_o),
    .startup_wait_o(startup_wait_o));

  pic_bus_master #(.HP(8)) bus_m (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (8) @(negedge clk_i);
  endtask : settle

  task automatic set_ptr(input logic [7:0] ptr);
    bus_m.start_cond();
    bus_m.wr_byte(PIC_WR_ADDR, a);
    chk({7'h00, a}, 8'h01);
    bus_m.wr_byte(ptr, a);
    chk({7'h00, a}, 8'h01);
  endtask : set_ptr

  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] dat, input logic stop);
    set_ptr(ptr);
    bus_m.wr_byte(dat, a);
    chk({7'h00, a}, 8'h01);
    if (stop) begin
      bus_m.stop_cond();
      settle();
    end
  endtask : wr_reg

  task automatic poll(output logic [7:0] v);
    bus_m.start_cond();
    bus_m.wr_byte(PIC_RD_ADDR, a);
    chk({7'h00, a}, 8'h01);
    bus_m.rd_byte(1'b0, v);
  endtask : poll

  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] v);
    set_ptr(ptr);
    poll(v);
  endtask : rd_reg

  // mode outputs mirror bits 6:0 of their register, enables and waits are 7 wide
  function automatic logic [7:0] view(input logic [7:0] ptr);
    if (ptr == PIC_MODE_OFS) return {1'b0, buckboost_burst_o, buck3_mode_o, buck2_mode_o,
                                     buck1_mode_o};
    if (ptr == PIC_OE_OFS) return {1'b0, regulator_enable_o};
    return {1'b0, startup_wait_o};
  endfunction : view

  task automatic pg_hold();
    power_good_output_low = 1'b1;
    repeat (PG_CYC + 10) @(negedge clk_i);
    chk({7'h00, power_good_output_o}, 8'h00);
    power_good_output_low = 1'b0;
    settle();
    chk({7'h00, power_good_output_o}, 8'h01);
  endtask : pg_hold

  always @(posedge clk_i) begin
    cyc++;
    if (hard_shutdown_o === 1'b1) sd_cnt++;
    if (power_good_output_timeout_o === 1'b1) to_cnt++;
    if (cyc == MAX_CYC) begin
      err_total++;
      $display("wrong value at %0t: run did not finish", $time);
      end_sim();
    end
  end

  initial begin
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    settle();
    rd_reg(PIC_MODE_OFS, d);
    chk(d, PIC_REG_RST);
    chk(view(PIC_OE_OFS), 8'h00);
    chk(view(PIC_STARTUP_OFS), 8'h7F);
    $display("test reset done");
    foreach (ROWS[i]) begin
      pins = ROWS[i].pins;
      wr_reg(ROWS[i].ptr, ROWS[i].dat, 1'b1);
      chk(view(ROWS[i].ptr), ROWS[i].exp);
      rd_reg(ROWS[i].ptr, d);
      chk(d, ROWS[i].dat);
    end
    $display("test table done");
    pins = 6'h00;
    // pending data is visible to reads but not to the outputs until a stop
    wr_reg(PIC_MODE_OFS, 8'h12, 1'b0);
    poll(d);
    chk(d, 8'h12);
    chk(view(PIC_MODE_OFS), 8'h19);
    poll(d);
    chk(d, 8'h12);
    bus_m.start_cond();
    bus_m.wr_byte(8'h50, a);
    chk({7'h00, a}, 8'h00);
    bus_m.stop_cond();
    settle();
    chk(view(PIC_MODE_OFS), 8'h12);
    set_ptr(PIC_MODE_OFS);
    bus_m.stop_cond();
    settle();
    chk(view(PIC_MODE_OFS), 8'h12);
    $display("test pending done");
    power_on_input = 1'b0;
    repeat (3) @(negedge clk_i);
    power_on_input = 1'b1;
    settle();
    chk(view(PIC_OE_OFS), 8'h00);
    $display("test power on done");
    wr_reg(PIC_STARTUP_OFS, 8'h80, 1'b1);
    pg_hold();
    chk(8'(to_cnt), 8'h01);
    chk(8'(sd_cnt), 8'h00);
    wr_reg(PIC_STARTUP_OFS, 8'h00, 1'b1);
    pg_hold();
    chk(8'(to_cnt), 8'h02);
    chk(8'(sd_cnt), 8'h01);
    $display("test power good done");
    wr_reg(PIC_MODE_OFS, 8'h33, 1'b1);
    supply_ok = 1'b0;
    repeat (4) @(negedge clk_i);
    supply_ok = 1'b1;
    settle();
    chk(view(PIC_MODE_OFS), 8'h00);
    rd_reg(PIC_MODE_OFS, d);
    chk(d, 8'h00);
    $display("test supply loss done");
    // last spare register, a master ack that repeats the byte, then an unmapped pointer
    wr_reg(8'h2A, 8'h5A, 1'b1);
    rd_reg(8'h2A, d);
    chk(d, 8'h5A);
    bus_m.start_cond();
    bus_m.wr_byte(PIC_RD_ADDR, a);
    chk({7'h00, a}, 8'h01);
    bus_m.rd_byte(1'b1, d);
    chk(d, 8'h5A);
    bus_m.rd_byte(1'b0, d);
    chk(d, 8'h5A);
    rd_reg(8'h2B, d);
    chk(d, PIC_UNMAPPED_RD);
    $display("test spare registers done");
    end_sim();
  end
endmodule : test_pic_command_port
